// >>> hw/qhp_pkg.sv
package qhp_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int DATA_W   = 8;
   localparam int REG_AW   = 3;
   localparam int CHAN_N   = 4;
   localparam int CHAN_AW  = 2;

   // ---------------------------------------------------------------
   // Channel indices and reset values
   // ---------------------------------------------------------------
   localparam logic [CHAN_AW-1:0] CHAN_A_IDX = 2'h0;
   localparam logic [CHAN_AW-1:0] CHAN_B_IDX = 2'h1;
   localparam logic [CHAN_AW-1:0] CHAN_C_IDX = 2'h2;
   localparam logic [CHAN_AW-1:0] CHAN_D_IDX = 2'h3;
   localparam logic               PIN_IDLE   = 1'h1;
   localparam logic               PIN_LOW    = 1'h0;

   // Bus style picked by the mode pin
   typedef enum logic [0:0] {
      QHP_STYLE_RW     = 1'b0,
      QHP_STYLE_STROBE = 1'b1
   } qhp_style_type;

   // Host pin group, as sampled on ref_clk
   typedef struct packed {
      logic                read_strobe_n;
      logic                write_strobe_n;
      logic [CHAN_N-1:0]   chan_select_n;   // a in bit 0 .. d in bit 3
      logic [REG_AW-1:0]   reg_addr;
      logic [DATA_W-1:0]   data_in;
   } qhp_host_pins_type;

   // Access request toward the channel register files
   typedef struct packed {
      logic                rd_start;
      logic                wr_start;
      logic                wr_commit;
      logic [CHAN_AW-1:0]  chan;
      logic [REG_AW-1:0]   reg_addr;
      logic [DATA_W-1:0]   wr_data;
   } qhp_access_type;

endpackage : qhp_pkg

// >>> hw/qhp_irq_pins.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Interrupt pin drivers for the four channels
// ------------------------------------------------------------------
module qhp_irq_pins #(
   parameter int CHAN_N = qhp_pkg::CHAN_N
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic              style_strobe,
   input  wire logic              interrupt_select_pin,
   input  wire logic [CHAN_N-1:0] chan_irq,
   input  wire logic [CHAN_N-1:0] interrupt_output_enable,
   output logic      [CHAN_N-1:0] irq_out,
   output logic      [CHAN_N-1:0] irq_oe
);

   logic [CHAN_N-1:0] irq_out_reg;
   logic [CHAN_N-1:0] irq_oe_reg;
   logic              any_irq;

   assign any_irq = |chan_irq;

   // Per-channel pin drive, registered so pins never glitch
   for (genvar i = 0; i < CHAN_N; i++) begin : g_pin
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            irq_out_reg[i] <= qhp_pkg::PIN_LOW;
            irq_oe_reg[i]  <= qhp_pkg::PIN_LOW;
         end else if (clk_en) begin
            if (style_strobe) begin
               // Select pin overrides the enable bit
               irq_out_reg[i] <= chan_irq[i];
               irq_oe_reg[i]  <= interrupt_select_pin | interrupt_output_enable[i];
            end else if (i == 0) begin
               // Shared open-drain request, only pulls low
               irq_out_reg[i] <= qhp_pkg::PIN_LOW;
               irq_oe_reg[i]  <= any_irq;
            end else begin
               // Unused lines held at logic zero
               irq_out_reg[i] <= qhp_pkg::PIN_LOW;
               irq_oe_reg[i]  <= qhp_pkg::PIN_IDLE;
            end
         end
      end
   end

   assign irq_out = irq_out_reg;
   assign irq_oe  = irq_oe_reg;

endmodule : qhp_irq_pins

// >>> hw/qhp_host_port.sv
`timescale 1ns/100ps

module qhp_host_port #(
   parameter int DATA_W = qhp_pkg::DATA_W,
   parameter int CHAN_N = qhp_pkg::CHAN_N
) (
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   input  wire logic                         clk_en,
   input  wire logic                         bus_style_select,
   input  wire logic                         interrupt_select_pin,
   input  wire qhp_pkg::qhp_host_pins_type   host_pins,
   output logic      [DATA_W-1:0]            data_out,
   output logic                              data_oe,
   output qhp_pkg::qhp_access_type           access,
   input  wire logic [DATA_W-1:0]            rd_data,
   input  wire logic [CHAN_N-1:0]            chan_irq,
   input  wire logic [CHAN_N-1:0]            interrupt_output_enable,
   input  wire logic [CHAN_N-1:0]            chan_tx_ready_n,
   input  wire logic [CHAN_N-1:0]            chan_rx_ready_n,
   output logic                              chan_a_irq_out,
   output logic                              chan_b_irq_out,
   output logic                              chan_c_irq_out,
   output logic                              chan_d_irq_out,
   output logic      [CHAN_N-1:0]            irq_oe,
   output logic                              tx_ready_all_n,
   output logic                              rx_ready_all_n
);

   // ---------------------------------------------------------------
   // Decode of style, channel and direction
   // ---------------------------------------------------------------
   qhp_pkg::qhp_style_type style;
   logic                   style_strobe;
   logic                   chan_hit;
   logic [1:0]             chan_sel;
   logic                   rd_active;
   logic                   wr_active;

   // Mode pin chooses the bus style
   assign style        = qhp_pkg::qhp_style_type'(bus_style_select);
   assign style_strobe = (style == qhp_pkg::QHP_STYLE_STROBE);

   // Channel decode; in strobe style the lowest select wins if the host asserts several
   always_comb begin
      chan_hit = 1'b0;
      chan_sel = qhp_pkg::CHAN_A_IDX;
      case (style)
         qhp_pkg::QHP_STYLE_STROBE: begin
            // One select per channel
            if (!host_pins.chan_select_n[0]) begin
               chan_hit = 1'b1;
               chan_sel = qhp_pkg::CHAN_A_IDX;
            end else if (!host_pins.chan_select_n[1]) begin
               chan_hit = 1'b1;
               chan_sel = qhp_pkg::CHAN_B_IDX;
            end else if (!host_pins.chan_select_n[2]) begin
               chan_hit = 1'b1;
               chan_sel = qhp_pkg::CHAN_C_IDX;
            end else if (!host_pins.chan_select_n[3]) begin
               chan_hit = 1'b1;
               chan_sel = qhp_pkg::CHAN_D_IDX;
            end
         end
         qhp_pkg::QHP_STYLE_RW: begin
            // Single chip select, two selects as address
            chan_hit = !host_pins.chan_select_n[0];
            chan_sel = host_pins.chan_select_n[2:1];
         end
         default: begin
            chan_hit = 1'b0;
            chan_sel = qhp_pkg::CHAN_A_IDX;
         end
      endcase
   end

   // Read and write phases; fourth select and read strobe unused in
   // read/write style, the host ties them high
   assign rd_active = chan_hit &&
                      (style_strobe ? !host_pins.read_strobe_n
                                    : host_pins.write_strobe_n);
   assign wr_active = chan_hit &&
                      (style_strobe ? !host_pins.write_strobe_n
                                    : !host_pins.write_strobe_n);

   // ---------------------------------------------------------------
   // Edge detection of the access phases
   // ---------------------------------------------------------------
   logic                 rd_active_reg;
   logic                 wr_active_reg;
   logic [1:0]           wr_chan_reg;
   logic [2:0]           wr_addr_reg;
   logic [DATA_W-1:0]    wr_data_reg;

   // Previous phase, to find starts and ends of strobes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_active_reg <= 1'b0;
         wr_active_reg <= 1'b0;
      end else if (clk_en) begin
         rd_active_reg <= rd_active;
         wr_active_reg <= wr_active;
      end
   end

   // Track address and data while the write phase is open, so the
   // commit at the strobe rise uses the last held byte
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_chan_reg <= qhp_pkg::CHAN_A_IDX;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
      end else if (clk_en && wr_active) begin
         wr_chan_reg <= chan_sel;
         wr_addr_reg <= host_pins.reg_addr;
         wr_data_reg <= host_pins.data_in;
      end
   end

   // Access requests to the channel register files
   always_comb begin
      access           = '0;
      access.rd_start  = clk_en && rd_active && !rd_active_reg;
      access.wr_start  = clk_en && wr_active && !wr_active_reg;
      access.wr_commit = clk_en && !wr_active && wr_active_reg;
      access.chan      = access.wr_commit ? wr_chan_reg : chan_sel;
      access.reg_addr  = access.wr_commit ? wr_addr_reg : host_pins.reg_addr;
      access.wr_data   = wr_data_reg;
   end

   // ---------------------------------------------------------------
   // Data bus drive
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] data_out_reg;
   logic              data_oe_reg;

   // Byte follows the register file while the read is held, so it is
   // stable at the strobe rise; released as soon as the read ends
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         data_out_reg <= '0;
         data_oe_reg  <= 1'b0;
      end else if (clk_en) begin
         data_oe_reg <= rd_active;
         if (rd_active) begin
            data_out_reg <= rd_data;
         end
      end
   end

   assign data_out = data_out_reg;
   assign data_oe  = data_oe_reg;

   // ---------------------------------------------------------------
   // Combined ready outputs
   // ---------------------------------------------------------------
   logic tx_all_reg;
   logic rx_all_reg;

   // Registered AND of the active-low channel statuses
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_all_reg <= qhp_pkg::PIN_IDLE;
         rx_all_reg <= qhp_pkg::PIN_IDLE;
      end else if (clk_en) begin
         tx_all_reg <= &chan_tx_ready_n;
         rx_all_reg <= &chan_rx_ready_n;
      end
   end

   assign tx_ready_all_n = tx_all_reg;
   assign rx_ready_all_n = rx_all_reg;

   // ---------------------------------------------------------------
   // Interrupt pins
   // ---------------------------------------------------------------
   logic [CHAN_N-1:0] irq_vec;

   qhp_irq_pins #(
      .CHAN_N (CHAN_N)
   ) u_irq_pins (
      .ref_clk                 (ref_clk),
      .rst_n                   (rst_n),
      .clk_en                  (clk_en),
      .style_strobe            (style_strobe),
      .interrupt_select_pin    (interrupt_select_pin),
      .chan_irq                (chan_irq),
      .interrupt_output_enable (interrupt_output_enable),
      .irq_out                 (irq_vec),
      .irq_oe                  (irq_oe)
   );

   assign chan_a_irq_out = irq_vec[0];
   assign chan_b_irq_out = irq_vec[1];
   assign chan_c_irq_out = irq_vec[2];
   assign chan_d_irq_out = irq_vec[3];

endmodule : qhp_host_port

// >>> sim/qhp_asserts.sv
`timescale 1ns/100ps
// ---------------------------------------
// Host port checker
// ---------------------------------------
module qhp_asserts (
   input wire logic                       ref_clk,
   input wire logic                       rst_n,
   input wire logic                       bus_style_select,
   input wire logic                       interrupt_select_pin,
   input wire qhp_pkg::qhp_host_pins_type host_pins,
   input wire logic [7:0]                 data_out,
   input wire logic                       data_oe,
   input wire qhp_pkg::qhp_access_type    access,
   input wire logic [7:0]                 rd_data,
   input wire logic [3:0]                 chan_irq,
   input wire logic [3:0]                 interrupt_output_enable,
   input wire logic [3:0]                 chan_tx_ready_n,
   input wire logic [3:0]                 chan_rx_ready_n,
   input wire logic                       chan_a_irq_out,
   input wire logic                       chan_b_irq_out,
   input wire logic                       chan_c_irq_out,
   input wire logic                       chan_d_irq_out,
   input wire logic [3:0]                 irq_oe,
   input wire logic                       tx_ready_all_n,
   input wire logic                       rx_ready_all_n
);
   logic [3:0] sel, oe_st, pins;
   logic [1:0] lo;
   logic       st, hit, rph, wph, any, rt, rr;
   // Phase decode as the host intends it
   assign st   = bus_style_select;
   assign sel  = host_pins.chan_select_n;
   assign hit  = st ? ~&sel : ~sel[0];
   assign rph  = hit && (st ? !host_pins.read_strobe_n : host_pins.write_strobe_n);
   assign wph  = hit && !host_pins.write_strobe_n;
   assign lo   = !sel[0] ? 2'h0 : !sel[1] ? 2'h1 : !sel[2] ? 2'h2 : 2'h3;
   assign oe_st = {4{interrupt_select_pin}} | interrupt_output_enable;
   assign any  = |chan_irq;
   assign pins = {chan_d_irq_out, chan_c_irq_out, chan_b_irq_out, chan_a_irq_out};
   assign rt   = &chan_tx_ready_n;
   assign rr   = &chan_rx_ready_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_open; !rph ##1 rph; endsequence
   sequence s_wr_done; wph ##1 !wph; endsequence
   property p_rd; access.rd_start == $rose(rph); endproperty
   a_rd: assert property (p_rd) else $error("read start wrong");
   property p_wr; access.wr_start == $rose(wph); endproperty
   a_wr: assert property (p_wr) else $error("write start wrong");
   property p_cm; s_wr_done |-> access.wr_commit && access.wr_data == $past(host_pins.data_in);
   endproperty
   a_cm: assert property (p_cm) else $error("write commit wrong");
   property p_oe; data_oe == $past(rph); endproperty
   a_oe: assert property (p_oe) else $error("bus enable wrong");
   property p_do; s_rd_open |=> data_oe && data_out == $past(rd_data); endproperty
   a_do: assert property (p_do) else $error("read byte wrong");
   property p_cs; access.rd_start && st |-> access.chan == lo && access.reg_addr == host_pins.reg_addr;
   endproperty
   a_cs: assert property (p_cs) else $error("strobe channel wrong");
   property p_cr; (access.rd_start || access.wr_start) && !st |-> access.chan == sel[2:1];
   endproperty
   a_cr: assert property (p_cr) else $error("rw channel wrong");
   property p_is; $past(rst_n) && $past(st) |-> irq_oe == $past(oe_st) && pins == $past(chan_irq);
   endproperty
   a_is: assert property (p_is) else $error("strobe irq pins wrong");
   property p_ir; $past(rst_n) && !$past(st) |-> pins == 4'h0 && irq_oe == {3'h7, $past(any)};
   endproperty
   a_ir: assert property (p_ir) else $error("rw irq pins wrong");
   property p_ry; $past(rst_n) |-> tx_ready_all_n == $past(rt) && rx_ready_all_n == $past(rr);
   endproperty
   a_ry: assert property (p_ry) else $error("ready outputs wrong");
endmodule : qhp_asserts

bind qhp_host_port qhp_asserts u_chk (.ref_clk, .rst_n, .bus_style_select,
   .interrupt_select_pin, .host_pins, .data_out, .data_oe, .access, .rd_data, .chan_irq,
   .interrupt_output_enable, .chan_tx_ready_n, .chan_rx_ready_n, .chan_a_irq_out,
   .chan_b_irq_out, .chan_c_irq_out, .chan_d_irq_out, .irq_oe, .tx_ready_all_n,
   .rx_ready_all_n);

// >>> sim/qhp_regs_model.sv
`timescale 1ns/100ps
// ---------------------------------------
// Channel register files
// ---------------------------------------
module qhp_regs_model (
   input  wire logic                    ref_clk,
   input  wire qhp_pkg::qhp_access_type access,
   output logic [7:0]                   rd_data
);
   logic [7:0] mem_reg [0:31];
   // Store only on commit, so a refused cycle leaves no trace
   always_ff @(posedge ref_clk) begin
      if (access.wr_commit) begin
         mem_reg[{access.chan, access.reg_addr}] <= access.wr_data;
      end
   end
   // No latency: the port samples this every cycle of a read
   assign rd_data = mem_reg[{access.chan, access.reg_addr}];
endmodule : qhp_regs_model

// >>> sim/qhp_host_port_bench.sv
`timescale 1ns/100ps
module qhp_host_port_bench;
   logic                       ref_clk = 1'b0;
   logic                       rst_n = 1'b0;
   logic                       bus_style_select = 1'b1;
   logic                       interrupt_select_pin = 1'b0;
   qhp_pkg::qhp_host_pins_type host_pins = '1;
   qhp_pkg::qhp_access_type    access;
   logic [7:0]                 data_out, rd_data;
   logic                       data_oe, oe_d = 1'b0;
   logic [3:0]                 chan_irq = 4'h0, irq_en = 4'h0, tx_n = 4'hF, rx_n = 4'hF;
   logic [3:0]                 irq_oe;
   logic                       irq_a, irq_b, irq_c, irq_d, tx_all_n, rx_all_n;
   logic [31:0]                seed = 32'h0000002B;
   logic [7:0]                 shadow [0:31];
   logic [7:0]                 exp_q [$];
   logic [9:0]                 side_q [$];
   logic [9:0]                 side_note;
   logic [3:0]                 irq_pins;
   int                         n_errors = 0;
   int                         checks_done = 0;

   qhp_host_port uut (.ref_clk, .rst_n, .clk_en(1'b1), .bus_style_select,
      .interrupt_select_pin, .host_pins, .data_out, .data_oe, .access, .rd_data, .chan_irq,
      .interrupt_output_enable(irq_en), .chan_tx_ready_n(tx_n), .chan_rx_ready_n(rx_n),
      .chan_a_irq_out(irq_a), .chan_b_irq_out(irq_b), .chan_c_irq_out(irq_c),
      .chan_d_irq_out(irq_d), .irq_oe, .tx_ready_all_n(tx_all_n), .rx_ready_all_n(rx_all_n));
   qhp_regs_model u_regs (.ref_clk, .access, .rd_data);

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e || $isunknown(s)) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   // One bus cycle from a negedge; three cycles held, then one idle cycle
   task automatic acc(input logic st, input logic [1:0] ch, input logic [2:0] a,
                      input logic wr, input logic hit, input logic [7:0] d);
      logic [3:0] sel;
      sel = !hit ? 4'hF : st ? ~(4'h1 << ch) : {1'b1, ch, 1'b0};
      bus_style_select = st;
      host_pins = {!st || wr, !wr, sel, a, d};
      if (hit && wr) shadow[{ch, a}] = d;
      if (hit && !wr) exp_q.push_back(shadow[{ch, a}]);
      repeat (3) @(negedge ref_clk);
      host_pins = {2'h3, 4'hF, a, ~d};
      @(negedge ref_clk);
   endtask : acc

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // Side inputs take a fresh random value every cycle to vary what the irq and ready checks see
   always @(negedge ref_clk) begin
      {interrupt_select_pin, chan_irq, irq_en, tx_n, rx_n} <= 17'(rnd());
   end

   // A read result is the byte held once the device lets go of the bus
   always @(negedge ref_clk) begin
      if (oe_d === 1'b1 && data_oe === 1'b0) begin
         check("data_out", exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX, data_out);
      end
      oe_d <= data_oe;
   end

   assign irq_pins = {irq_d, irq_c, irq_b, irq_a};

   // Note what pins and ready outputs must show once this edge lands
   always @(posedge ref_clk) begin
      if (rst_n === 1'b1) begin
         side_q.push_back({&tx_n, &rx_n,
                           bus_style_select ? chan_irq : 4'h0,
                           bus_style_select ? ({4{interrupt_select_pin}} | irq_en)
                                            : {3'h7, |chan_irq}});
      end
   end

   // Registered outputs have settled by the falling edge after
   always @(negedge ref_clk) begin
      if (side_q.size() != 0) begin
         side_note = side_q.pop_front();
         check("ready", 8'(side_note[9:8]), {6'h00, tx_all_n, rx_all_n});
         check("irq out", 8'(side_note[7:4]), 8'(irq_pins));
         check("irq oe", 8'(side_note[3:0]), 8'(irq_oe));
      end
   end

   initial begin
      repeat (5) @(negedge ref_clk);
      check("reset outputs", 8'h03, {5'h00, data_oe, tx_all_n, rx_all_n});
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, i[1:0], i[2:0], 1'b1, 1'b1, 8'(rnd()));
         acc(1'b1, i[1:0], i[2:0], 1'b0, 1'b1, 8'h00);
      end
      $display("strobe style test done");
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, i[1:0], ~i[2:0], 1'b1, 1'b1, 8'(rnd()));
         acc(1'b0, i[1:0], ~i[2:0], 1'b0, 1'b1, 8'h00);
         acc(1'b1, i[1:0], ~i[2:0], 1'b0, 1'b1, 8'h00);
      end
      $display("read write style test done");
      for (int i = 0; i < 4; i++) begin
         acc(i[0], i[1:0], i[2:0], 1'b1, 1'b0, 8'(rnd()));
         acc(i[0], i[1:0], i[2:0], 1'b0, 1'b0, 8'h00);
         acc(1'b1, i[1:0], i[2:0], 1'b0, 1'b1, 8'h00);
      end
      $display("unselected access test done");
      repeat (4) @(negedge ref_clk);
      check("pending reads", 8'h00, 8'(exp_q.size()));
      wrap_up();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      wrap_up();
   end
endmodule : qhp_host_port_bench
